// ---- logic/lfs_consts.vh ----
// Timing constants and encodings for the LED driver fault supervisor.
`ifndef LFS_CONSTS_VH
`define LFS_CONSTS_VH
`define LFS_CLK_PERIOD_NS     10
`define LFS_CLEAR_TIME_MS     16
`define LFS_CLEAR_CYCLES      ((`LFS_CLEAR_TIME_MS * 1000000) / `LFS_CLK_PERIOD_NS)
`define LFS_PSD_TIME_NS       5500
`define LFS_PSD_CYCLES        (`LFS_PSD_TIME_NS / `LFS_CLK_PERIOD_NS)
`define LFS_CNT_W             21
`define LFS_ST_OFF            2'h0
`define LFS_ST_SOFT_START     2'h1
`define LFS_ST_RUN            2'h2
`define LFS_ST_LATCHED        2'h3
`endif

// ---- logic/lfs_fault_supervisor.v ----
// Fault supervision and recovery for a four-string boost LED driver.
// Functional notes
// R1: Primary current limit ends present on-time only; next cycle starts normally.
// R2: Secondary switch overcurrent shuts everything off, sets flag, latches.
// R3: Input sense trip shuts everything off, sets flag, latches.
// R4: Secondary overvoltage shuts everything off, sets flag, latches.
// R5: LED pin ground short at first dim-high halts soft-start; no flag.
// R6: Open string raises output to overvoltage, then disables unregulated strings.
// R7: Current-set short stops boost and sinks, keeps disconnect on, sets flag.
// R8: Frequency-set short turns all off, sets flag, restarts through soft-start.
// R9: Overvoltage stops switching only, no flag, resumes when detector releases.
// R10: Output undervoltage stops boost and sinks, keeps disconnect, sets flag.
// R11: Partial short disables offending string only, auto-restart, no flag.
// R12: Partial short needs dimming on-time of at least detection time.
// R13: Overtemperature turns all off, sets flag, auto-restarts after hysteresis.
// R14: Supply lockout turns all off without flag and clears latched faults.
// R15: Fault detection is active in every state and transition; open-string and partial-short checks act only in RUN.
// R16: Only the three overcurrent/overvoltage faults latch; others auto-restart.
// R17: Latch clears by lockout, enable low 16 ms, or dimming low 16 ms.
// R18: Clearing through dimming input keeps clock output running.
// R19: Fault still present at clear trips again and stays latched.
// R20: Fault flag follows flag-setting faults present or a latched fault.
// R21: Low-time counters restart whenever the input returns high.
`timescale 1ns/100ps
`include "lfs_consts.vh"

module lfs_fault_supervisor
#(
    parameter NUM_STRINGS   = 4,
    parameter CLEAR_CYCLES  = `LFS_CLEAR_CYCLES,
    parameter PSD_CYCLES    = `LFS_PSD_CYCLES,
    parameter SS_CYCLES     = 1000
)
(
    // Clock and reset
    input  wire                   i_ref_clk,
    input  wire                   i_reset_n,
    // Host controls
    input  wire                   i_enable,
    input  wire                   i_pwm_dim,
    // Boost switching request and clock-output run control from the converter loop
    input  wire                   i_boost_gate_req,
    input  wire                   i_clock_run,
    // Fault detectors
    input  wire                   i_primary_switch_current_limit,
    input  wire                   i_secondary_switch_current_limit,
    input  wire                   i_input_sense_trip_level,
    input  wire                   i_secondary_overvoltage_level,
    input  wire                   i_overvoltage_protect,
    input  wire                   i_output_undervoltage_level,
    input  wire                   i_current_set_resistor_short,
    input  wire                   i_frequency_set_sync_pin_short,
    input  wire                   i_over_temperature,
    input  wire                   i_supply_lockout,
    input  wire [NUM_STRINGS-1:0] i_led_pin_grounded,
    input  wire [NUM_STRINGS-1:0] i_led_out_of_reg,
    input  wire [NUM_STRINGS-1:0] i_led_over_partial_short_level,
    input  wire [NUM_STRINGS-1:0] i_led_below_low_level,
    // Outputs
    output reg                    o_boost_switch_node,
    output reg                    o_disconnect_switch,
    output reg  [NUM_STRINGS-1:0] o_led_sink_enable,
    output reg                    o_fault_flag,
    output reg                    o_fault_latched,
    output reg                    o_soft_start_active,
    output reg                    o_clock_output
);

    reg [1:0]             state;
    reg [1:0]             next_state;
    reg                   latched;
    reg                   pwm_prev;
    reg                   pwm_seen;
    reg                   ss_hold;
    reg [31:0]            ss_cnt;
    reg [`LFS_CNT_W-1:0]  en_low_cnt;
    reg [`LFS_CNT_W-1:0]  pwm_low_cnt;
    reg [15:0]            pwm_on_cnt;
    reg [NUM_STRINGS-1:0] string_off;
    reg [NUM_STRINGS-1:0] psc_off;
    reg                   ovp_seen;
    reg                   clk_div;

    // Latch trigger sources
    wire latch_src = i_secondary_switch_current_limit | i_input_sense_trip_level |
                     i_secondary_overvoltage_level;
    // The enable low-time counter saturates at the clear count; the dimming one saturates only
    // while enable is high, and with enable low it can wrap round and look like a fresh short low time.
    wire en_clear  = (en_low_cnt >= CLEAR_CYCLES[`LFS_CNT_W-1:0]);
    wire pwm_clear = i_enable & (pwm_low_cnt >= CLEAR_CYCLES[`LFS_CNT_W-1:0]);
    // Faults that take the whole converter down and restart through soft-start.
    wire all_off   = i_frequency_set_sync_pin_short | i_over_temperature | i_supply_lockout;
    wire sink_off  = i_current_set_resistor_short | i_output_undervoltage_level;
    wire flag_src  = i_current_set_resistor_short | i_frequency_set_sync_pin_short |
                     i_output_undervoltage_level | i_over_temperature;
    wire any_short = |i_led_pin_grounded;
    wire first_short_rise = i_pwm_dim & ~pwm_prev & ~pwm_seen & any_short;
    wire psd_ok    = (pwm_on_cnt >= PSD_CYCLES[15:0]);
    wire [NUM_STRINGS-1:0] partial_hit;
    reg                    next_latched;

    genvar g;
    generate
        for (g = 0; g < NUM_STRINGS; g = g + 1)
        begin : g_psc
            // R11 other pin low
            assign partial_hit[g] = i_led_over_partial_short_level[g] & ~i_led_out_of_reg[g] &
                                    |(i_led_below_low_level & ~({{(NUM_STRINGS-1){1'b0}},
                                    1'b1} << g));
        end
    endgenerate

    always @*
    begin
        next_latched = latched;
        // R17 three clear paths
        if (i_supply_lockout | en_clear | pwm_clear)
            next_latched = 1'b0;
        // R16 latching set wins over the enable and dimming clears; lockout blocks it
        if (latch_src & ~i_supply_lockout)
            next_latched = 1'b1;
    end

    always @*
    begin
        next_state = state;
        // R15 checked in all states
        case (state)
            `LFS_ST_OFF:
                if (i_enable & i_pwm_dim & ~all_off & ~next_latched)
                    next_state = `LFS_ST_SOFT_START;
            `LFS_ST_SOFT_START:
                if (ss_cnt >= SS_CYCLES)
                    next_state = `LFS_ST_RUN;
            `LFS_ST_RUN:
                next_state = `LFS_ST_RUN;
            `LFS_ST_LATCHED:
                if (~next_latched)
                    next_state = `LFS_ST_OFF;
            default:
                next_state = `LFS_ST_OFF;
        endcase
        if (next_latched)
            next_state = `LFS_ST_LATCHED;
        // R8 restart via soft-start
        else if (state != `LFS_ST_LATCHED && (all_off | ~i_enable))
            next_state = `LFS_ST_OFF;
    end

    // State, latch and the low-time counters.
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            state       <= `LFS_ST_OFF;
            latched     <= 1'b0;
            en_low_cnt  <= {`LFS_CNT_W{1'b0}};
            pwm_low_cnt <= {`LFS_CNT_W{1'b0}};
            pwm_on_cnt  <= 16'h0;
        end
        else
        begin
            state   <= next_state;
            latched <= next_latched;
            // R21 enable low time
            if (i_enable)
                en_low_cnt <= {`LFS_CNT_W{1'b0}};
            else if (!en_clear)
                en_low_cnt <= en_low_cnt + 1'b1;
            // R21 dimming low time
            if (i_pwm_dim)
                pwm_low_cnt <= {`LFS_CNT_W{1'b0}};
            else if (!pwm_clear)
                pwm_low_cnt <= pwm_low_cnt + 1'b1;
            // R12 dimming on-time gate
            if (!i_pwm_dim)
                pwm_on_cnt <= 16'h0;
            else if (!psd_ok)
                pwm_on_cnt <= pwm_on_cnt + 1'b1;
        end
    end

    // Soft-start hold on a grounded pin at the first dimming rise.
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            pwm_prev <= 1'b0;
            pwm_seen <= 1'b0;
            ss_hold  <= 1'b0;
            ss_cnt   <= 32'h0;
        end
        else
        begin
            pwm_prev <= i_pwm_dim;
            // R5 first dimming rise
            if (next_state == `LFS_ST_OFF)
                pwm_seen <= 1'b0;
            else if (i_pwm_dim & ~pwm_prev)
                pwm_seen <= 1'b1;
            // The hold is armed only at the first rise, so a short that shows
            // up later in the run is left to the other detectors.
            if (next_state != `LFS_ST_SOFT_START)
                ss_hold <= 1'b0;
            else if (first_short_rise)
                ss_hold <= 1'b1;
            else if (~any_short)
                ss_hold <= 1'b0;
            if (state != `LFS_ST_SOFT_START)
                ss_cnt <= 32'h0;
            else if (!ss_hold && !first_short_rise)
                ss_cnt <= ss_cnt + 32'h1;
        end
    end

    // Strings removed by the open-string and partial-short checks.
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            ovp_seen   <= 1'b0;
            string_off <= {NUM_STRINGS{1'b0}};
            psc_off    <= {NUM_STRINGS{1'b0}};
        end
        else
        begin
            // R6 open string after overvoltage
            ovp_seen <= i_overvoltage_protect & (|i_led_out_of_reg) & (state == `LFS_ST_RUN);
            if (state != `LFS_ST_RUN)
                string_off <= {NUM_STRINGS{1'b0}};
            else if (ovp_seen)
                string_off <= string_off | i_led_out_of_reg;
            // R11 drop shorted string
            // A partial short is judged afresh each cycle, so the string returns once it recovers.
            if (state != `LFS_ST_RUN)
                psc_off <= {NUM_STRINGS{1'b0}};
            else
                psc_off <= partial_hit & {NUM_STRINGS{psd_ok}};
        end
    end

    // R18 clock runs while enabled
    // A dimming clear leaves this running; only enable low or i_clock_run low stops it.
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            clk_div        <= 1'b0;
            o_clock_output <= 1'b0;
        end
        else
        begin
            if (i_clock_run & i_enable)
                clk_div <= ~clk_div;
            o_clock_output <= clk_div;
        end
    end

    // Switch, sink and flag outputs, all registered.
    // Keeping them in flip-flops costs one cycle of reaction to each detector; partial-short string removal takes two and open-string removal three.
    always @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            o_boost_switch_node <= 1'b0;
            o_disconnect_switch <= 1'b0;
            o_led_sink_enable   <= {NUM_STRINGS{1'b0}};
            o_fault_flag        <= 1'b0;
            o_fault_latched     <= 1'b0;
            o_soft_start_active <= 1'b0;
        end
        else
        begin
            // R2 R3 R4 R14 all off
            if (next_latched | all_off | next_state == `LFS_ST_OFF)
            begin
                o_boost_switch_node <= 1'b0;
                o_disconnect_switch <= 1'b0;
                o_led_sink_enable   <= {NUM_STRINGS{1'b0}};
            end
            // R5 R7 R10 sinks off
            else if (sink_off | ss_hold | first_short_rise)
            begin
                o_boost_switch_node <= 1'b0;
                o_disconnect_switch <= 1'b1;
                o_led_sink_enable   <= {NUM_STRINGS{1'b0}};
            end
            else
            begin
                // R1 R9 truncate on-time
                o_boost_switch_node <= i_boost_gate_req & ~i_primary_switch_current_limit &
                                       ~i_overvoltage_protect;
                o_disconnect_switch <= 1'b1;
                o_led_sink_enable   <= {NUM_STRINGS{i_pwm_dim}} & ~string_off & ~psc_off;
            end
            // R20 flag sources
            o_fault_flag        <= next_latched | flag_src;
            o_fault_latched     <= next_latched;
            o_soft_start_active <= (next_state == `LFS_ST_SOFT_START);
        end
    end

    // R19 re-trip is natural: a live source sets the latch again on the clear cycle.

endmodule // lfs_fault_supervisor

// ---- bench/lfs_host_model.sv ----
// Host controller model that drives the enable and dimming levels.
`timescale 1ns/100ps
module lfs_host_model
(
    // Clock
    input  wire i_ref_clk,
    // Host levels
    output reg  o_enable,
    output reg  o_pwm_dim
);
    initial
    begin
        o_enable = 1'b0;
        o_pwm_dim = 1'b0;
    end
    task drive(input logic en, input logic pwm, input int n);
        @(posedge i_ref_clk);
        #1;
        o_enable = en;
        o_pwm_dim = pwm;
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
endmodule // lfs_host_model

// ---- bench/lfs_sup_assertions.sv ----
// Checker for the fault supervisor outputs.
`timescale 1ns/100ps
module lfs_sup_assertions #(parameter NUM_STRINGS = 4)
(
    input wire i_ref_clk, i_reset_n, i_enable, i_pwm_dim, i_supply_lockout,
    input wire i_secondary_switch_current_limit, i_input_sense_trip_level,
    input wire i_secondary_overvoltage_level, i_primary_switch_current_limit,
    input wire i_overvoltage_protect, i_output_undervoltage_level, i_over_temperature,
    input wire i_current_set_resistor_short, i_frequency_set_sync_pin_short,
    input wire o_boost_switch_node, o_disconnect_switch, o_fault_flag, o_fault_latched,
    input wire [NUM_STRINGS-1:0] o_led_sink_enable
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    wire hit = i_secondary_switch_current_limit | i_input_sense_trip_level
        | i_secondary_overvoltage_level;
    wire dark = !o_boost_switch_node && !o_disconnect_switch && o_led_sink_enable == 0;
    wire no_sw = !o_boost_switch_node && o_led_sink_enable == 0;
    a_latch_sets: assert property (hit && !i_supply_lockout |=> o_fault_latched && o_fault_flag
        && dark) else $error("latch not set");
    a_latch_holds: assert property (o_fault_latched && !i_supply_lockout && i_enable && i_pwm_dim
        |=> o_fault_latched) else $error("latch lost");
    a_lockout_clears: assert property (i_supply_lockout |=> !o_fault_latched && !o_fault_flag
        && dark) else $error("lockout");
    a_primary_trunc: assert property (i_primary_switch_current_limit |=> !o_boost_switch_node)
        else $error("on-time kept");
    a_ovp_stops: assert property (i_overvoltage_protect |=> !o_boost_switch_node)
        else $error("ovp switching");
    a_current_set_resistor_stops: assert property (i_current_set_resistor_short |=> no_sw && o_fault_flag)
        else $error("current_set_resistor");
    a_fset_off: assert property (i_frequency_set_sync_pin_short |=> dark && o_fault_flag)
        else $error("fset");
    a_uvp_stops: assert property (i_output_undervoltage_level |=> no_sw && o_fault_flag)
        else $error("uvp");
    a_hot_off: assert property (i_over_temperature |=> dark && o_fault_flag)
        else $error("overtemp");
    a_flag_latch: assert property (o_fault_latched |-> o_fault_flag)
        else $error("flag low");
endmodule // lfs_sup_assertions
bind lfs_fault_supervisor lfs_sup_assertions #(.NUM_STRINGS(NUM_STRINGS)) lfs_sup_assertions_inst
    (.*);

// ---- bench/tb_top.sv ----
// Self-checking bench for the fault supervisor.
`timescale 1ns/100ps
module tb_top;
    localparam CLR = 20;
    localparam SS = 8;
    logic i_ref_clk = 0, i_reset_n = 0, cp = 0;
    logic [9:0] f = 10'h0;
    logic [3:0] gnd = 4'h0, oor = 4'h0, psl = 4'h0, low = 4'h0;
    wire i_enable, i_pwm_dim, boost, disc, flag, lat, clk_o;
    wire [3:0] sink;
    int error_cnt = 0, checked = 0, tg = 0, t0, cyc_n = 0;
    logic [2:0] ex [0:8] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3, 3'h3, 3'h1, 3'h1};
    always #5 i_ref_clk = ~i_ref_clk;
    lfs_host_model lfs_host_model_inst (.i_ref_clk, .o_enable(i_enable), .o_pwm_dim(i_pwm_dim));
    lfs_fault_supervisor #(.CLEAR_CYCLES(CLR), .PSD_CYCLES(4), .SS_CYCLES(SS))
    lfs_fault_supervisor_inst (.i_ref_clk, .i_reset_n, .i_enable, .i_pwm_dim,
        .i_boost_gate_req(1'b1), .i_clock_run(1'b1),
        .i_primary_switch_current_limit(f[0]), .i_secondary_switch_current_limit(f[1]),
        .i_input_sense_trip_level(f[2]), .i_secondary_overvoltage_level(f[3]),
        .i_overvoltage_protect(f[4]), .i_output_undervoltage_level(f[5]),
        .i_current_set_resistor_short(f[6]), .i_frequency_set_sync_pin_short(f[7]),
        .i_over_temperature(f[8]), .i_supply_lockout(f[9]), .i_led_pin_grounded(gnd),
        .i_led_out_of_reg(oor), .i_led_over_partial_short_level(psl),
        .i_led_below_low_level(low), .o_boost_switch_node(boost), .o_disconnect_switch(disc),
        .o_led_sink_enable(sink), .o_fault_flag(flag), .o_fault_latched(lat),
        .o_soft_start_active(), .o_clock_output(clk_o));
    // Counts output clock toggles so a stalled clock shows during a dimming clear.
    always @(posedge i_ref_clk)
    begin
        tg <= tg + (clk_o !== cp);
        cp <= clk_o;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 3000)
        begin
            error_cnt++;
            test_done;
        end
    end
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task look(input logic [2:0] e, input logic [3:0] s);
        chk({1'b0, boost, disc, flag}, {1'b0, e});
        chk(sink, s);
    endtask
    task hold(input logic en, input logic pwm, input int n);
        lfs_host_model_inst.drive(en, pwm, n);
    endtask
    task start;
        hold(1'b1, 1'b1, SS + 4);
        look(3'h6, 4'hf);
    endtask
    task t_latch(input int k);
        start;
        f[k] = 1'b1;
        cyc(1);
        look(3'h1, 4'h0);
        hold(1'b1, 1'b0, CLR + 3);
        chk(4'(lat), 4'h1);
        hold(1'b1, 1'b1, 1);
        f[k] = 1'b0;
        cyc(4);
        chk(4'(lat), 4'h1);
        if (k == 1)
            hold(1'b0, 1'b0, CLR + 3);
        if (k == 2)
        begin
            f[9] = 1'b1;
            cyc(1);
            look(3'h0, 4'h0);
            f[9] = 1'b0;
        end
        if (k == 3)
        begin
            hold(1'b1, 1'b0, CLR - 4);
            hold(1'b1, 1'b1, 1);
            hold(1'b1, 1'b0, CLR - 4);
            chk(4'(lat), 4'h1);
            t0 = tg;
            hold(1'b1, 1'b0, CLR + 3);
            chk(4'(tg - t0 > CLR), 4'h1);
        end
        chk(4'(lat), 4'h0);
    endtask
    task t_auto(input int k);
        start;
        f[k] = 1'b1;
        cyc(1);
        look(ex[k], (k == 0 || k == 4) ? 4'hf : 4'h0);
        f[k] = 1'b0;
        cyc(SS + 4);
        look(3'h6, 4'hf);
    endtask
    task t_ground;
        hold(1'b0, 1'b0, 3);
        gnd = 4'h2;
        hold(1'b1, 1'b1, SS + 4);
        look(3'h2, 4'h0);
        gnd = 4'h0;
        cyc(SS + 4);
        look(3'h6, 4'hf);
    endtask
    task t_strings;
        start;
        psl = 4'h2;
        low = 4'h4;
        cyc(8);
        look(3'h6, 4'hd);
        psl = 4'h0;
        low = 4'h0;
        oor = 4'h8;
        f[4] = 1'b1;
        cyc(4);
        f[4] = 1'b0;
        cyc(2);
        look(3'h6, 4'h7);
    endtask
    task test_done;
        $display("%0d mismatches in %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        cyc(16);
        i_reset_n = 1'b1;
        cyc(1);
        look(3'h0, 4'h0);
        for (int k = 1; k < 4; k++)
            t_latch(k);
        for (int k = 0; k < 9; k++)
            if (k == 0 || k > 3)
                t_auto(k);
        t_ground;
        t_strings;
        test_done;
    end
endmodule // tb_top
